/* rtc_locked_indirect_access_test.sv */
// self-checking bench for the locked indirect access block
`timescale 1ns/10ps
`include "rtcia_defines.vh"
module rtc_locked_indirect_access_test;
    localparam [7:0] KEY_A = `RTCIA_SFR_KEY;
    localparam [7:0] ADR_A = `RTCIA_SFR_ADR;
    localparam [7:0] DAT_A = `RTCIA_SFR_DAT;
    reg        clock;
    reg        rst;
    reg  [7:0] sfr_addr;
    reg        sfr_wr;
    reg        sfr_rd;
    reg  [7:0] sfr_wdata;
    reg        tick_pin;
    reg  [7:0] rd_val;
    reg  [7:0] exp_v;
    wire [7:0] sfr_rdata;
    wire       busy;
    wire       alarm_event;
    wire       missing_clock_event;
    integer    mismatches;
    integer    compares;
    integer    cycles;
    integer    n;
    integer    b;
    integer    i;
    integer    alarm_seen;
    integer    miss_seen;

    rtcia_top #(.MISS_CYCLES(16'd20)) u_dut (
        .clock(clock), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .tick_pin(tick_pin),
        .sfr_rdata(sfr_rdata), .busy(busy), .alarm_event(alarm_event),
        .missing_clock_event(missing_clock_event));

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    task results;
        begin
            $display("mismatches=%0d compares=%0d", mismatches, compares);
            if (mismatches == 0 && compares > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask

    initial begin
        cycles = 0;
        forever begin
            @(posedge clock);
            cycles = cycles + 1;
            if (cycles == 5000) begin
                mismatches = mismatches + 1;
                results;
            end
        end
    end

    task wr(input [7:0] a, input [7:0] d);
        begin
            @(negedge clock);
            sfr_addr  = a;
            sfr_wdata = d;
            sfr_wr    = 1'b1;
            @(negedge clock);
            sfr_wr    = 1'b0;
        end
    endtask

    task rd(input [7:0] a);
        begin
            @(negedge clock);
            sfr_addr = a;
            sfr_rd   = 1'b1;
            @(negedge clock);
            sfr_rd   = 1'b0;
            rd_val   = sfr_rdata;
        end
    endtask

    task cmp(input [7:0] got, input [7:0] exp);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
                mismatches = mismatches + 1;
            end
        end
    endtask

    // counts busy cycles seen from the current one
    task wait_idle;
        begin
            n = 0;
            while (busy !== 1'b0 && n < 50) begin
                n = n + 1;
                @(negedge clock);
            end
        end
    endtask

    task unlock;
        begin
            wr(KEY_A, `RTCIA_KEY_FIRST);
            wr(KEY_A, `RTCIA_KEY_SECOND);
        end
    endtask

    // one slow tick pulse, long enough for the synchroniser
    task tick;
        begin
            @(negedge clock);
            tick_pin = 1'b1;
            repeat (3) @(negedge clock);
            tick_pin = 1'b0;
            repeat (3) @(negedge clock);
        end
    endtask

    // event pulses counted where they are settled
    always @(negedge clock) begin
        if (alarm_event === 1'b1)
            alarm_seen = alarm_seen + 1;
        if (missing_clock_event === 1'b1)
            miss_seen = miss_seen + 1;
    end

    initial begin
        mismatches = 0;
        compares   = 0;
        rst        = 1'b1;
        sfr_addr   = 8'h00;
        sfr_wr     = 1'b0;
        sfr_rd     = 1'b0;
        sfr_wdata  = 8'h00;
        tick_pin   = 1'b0;
        alarm_seen = 0;
        miss_seen  = 0;
        repeat (20) @(negedge clock);
        rst = 1'b0;
        rd(KEY_A);
        cmp(rd_val, `RTCIA_CODE_LOCKED);
        wr(KEY_A, `RTCIA_KEY_FIRST);
        repeat (100) @(negedge clock);
        rd(KEY_A);
        cmp(rd_val, `RTCIA_CODE_KEY1);
        wr(KEY_A, `RTCIA_KEY_SECOND);
        rd(KEY_A);
        cmp(rd_val, `RTCIA_CODE_OPEN);
        wr(ADR_A, 8'h14);
        wr(DAT_A, 8'h02);
        wait_idle;
        cmp(n[7:0], 8'd6);
        wr(ADR_A, 8'h84);
        wait_idle;
        cmp(n[7:0], 8'd7);
        rd(DAT_A);
        cmp(rd_val, 8'h02);
        rd(DAT_A);
        cmp(rd_val, 8'h02);
        rd(ADR_A);
        cmp(rd_val, 8'h04);
        for (b = 0; b < 2; b = b + 1) begin
            wr(ADR_A, 8'h10 | {b[4:0], 3'b000});
            for (i = 0; i < 4; i = i + 1) begin
                exp_v = 8'h40 + {b[4:0], 3'b000} + i[7:0];
                wr(DAT_A, exp_v);
                wait_idle;
            end
            rd(ADR_A);
            cmp(rd_val, 8'h14 + {b[4:0], 3'b000});
            wr(ADR_A, 8'hd0 | {b[4:0], 3'b000});
            wait_idle;
            for (i = 0; i < 4; i = i + 1) begin
                rd(DAT_A);
                cmp(rd_val, 8'h40 + {b[4:0], 3'b000} + i[7:0]);
                wait_idle;
            end
        end
        // alarm two ticks ahead of the counter, then all events on
        wr(ADR_A, 8'h18);
        for (i = 0; i < 4; i = i + 1) begin
            wr(DAT_A, (i == 0) ? 8'h42 : 8'h40 + i[7:0]);
            wait_idle;
        end
        wr(ADR_A, 8'h14);
        wr(DAT_A, 8'h07);
        wait_idle;
        tick;
        cmp(alarm_seen[7:0], 8'd0);
        tick;
        cmp(alarm_seen[7:0], 8'd1);
        cmp(miss_seen[7:0], 8'd0);
        repeat (30) @(negedge clock);
        cmp(miss_seen[7:0], 8'd1);
        cmp(alarm_seen[7:0], 8'd1);
        // single short strobe read with fixed spacing, no polling
        wr(ADR_A, 8'h95);
        repeat (5) @(negedge clock);
        rd(DAT_A);
        cmp(rd_val, 8'h00);
        wr(ADR_A, 8'h17);
        wr(DAT_A, 8'h3c);
        wait_idle;
        wr(KEY_A, 8'h00);
        rd(KEY_A);
        cmp(rd_val, `RTCIA_CODE_LOCKED);
        rd(DAT_A);
        cmp(rd_val, 8'h00);
        rd(KEY_A);
        cmp(rd_val, `RTCIA_CODE_DEAD);
        wr(KEY_A, `RTCIA_KEY_FIRST);
        rd(KEY_A);
        cmp(rd_val, `RTCIA_CODE_DEAD);
        rst = 1'b1;
        repeat (2) @(negedge clock);
        rst = 1'b0;
        unlock;
        rd(ADR_A);
        cmp(rd_val, 8'h17);
        rd(DAT_A);
        cmp(rd_val, 8'h3c);
        wr(KEY_A, 8'h00);
        wr(KEY_A, `RTCIA_KEY_SECOND);
        rd(KEY_A);
        cmp(rd_val, `RTCIA_CODE_DEAD);
        results;
    end
endmodule

/* rtcia_assertions.sv */
// checker for the locked indirect access block
`timescale 1ns/10ps
`include "rtcia_defines.vh"
module rtcia_checker #(
    parameter [15:0] MISS_CYCLES = `RTCIA_MISS_CYC
) (
    input wire       clock,
    input wire       rst,
    input wire [7:0] sfr_addr,
    input wire       sfr_wr,
    input wire       sfr_rd,
    input wire [7:0] sfr_wdata,
    input wire       tick_pin,
    input wire [7:0] sfr_rdata,
    input wire       busy,
    input wire       alarm_event,
    input wire       missing_clock_event
);
    reg  [1:0] lock_ff;
    reg        short_ff;
    reg        ar_ff;
    wire       key_wr;
    wire       ia_acc;
    wire       adr_wr;
    assign key_wr = sfr_wr && sfr_addr == `RTCIA_SFR_KEY;
    assign ia_acc = (sfr_wr || sfr_rd) && (sfr_addr == `RTCIA_SFR_ADR
                    || sfr_addr == `RTCIA_SFR_DAT);
    assign adr_wr = sfr_wr && sfr_addr == `RTCIA_SFR_ADR
                    && lock_ff == 2'd2 && !busy;
    // shadow of lock state and mode bits
    always @(posedge clock) begin
        if (rst) begin
            lock_ff  <= 2'd0;
            short_ff <= `RTCIA_SHORT_RST;
            ar_ff    <= `RTCIA_AUTO_READ_ENABLE_RST;
        end else begin
            if (key_wr) begin
                case (lock_ff)
                    2'd0: lock_ff <= (sfr_wdata == `RTCIA_KEY_FIRST)
                                     ? 2'd1 : 2'd3;
                    2'd1: lock_ff <= (sfr_wdata == `RTCIA_KEY_SECOND)
                                     ? 2'd2 : 2'd3;
                    2'd2: lock_ff <= 2'd0;
                    default: lock_ff <= 2'd3;
                endcase
            end else if (ia_acc && lock_ff != 2'd2) begin
                lock_ff <= 2'd3;
            end
            if (adr_wr) begin
                short_ff <= sfr_wdata[`RTCIA_ADR_SHORT];
                ar_ff    <= sfr_wdata[`RTCIA_ADR_AUTO_READ_ENABLE];
            end
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    AST_SHORT_LEN: assert property ($rose(busy) && short_ff |->
        busy [*6] ##1 !busy) else $error("short access length wrong");
    AST_LONG_LEN: assert property ($rose(busy) && !short_ff |->
        busy [*7] ##1 !busy) else $error("long access length wrong");
    AST_BUSY_CAUSE: assert property ($rose(busy) |->
        $past(sfr_wr) || $past(sfr_rd)) else $error("busy without request");
    AST_RDATA_HOLD: assert property (!sfr_rd |=>
        $stable(sfr_rdata)) else $error("read data moved");
    AST_KEY_READ: assert property (
        sfr_rd && sfr_addr == `RTCIA_SFR_KEY |=>
        sfr_rdata == {6'h00, $past(lock_ff)}) else $error("bad lock status");
    AST_LOCKED_RD: assert property (
        sfr_rd && ia_acc && lock_ff != 2'd2 |=> sfr_rdata == 8'h00)
        else $error("locked read leaked data");
    AST_DEAD_IDLE: assert property (lock_ff == 2'd3 && !busy |=>
        !busy) else $error("access started while disabled");
    AST_ADR_READ: assert property (
        sfr_rd && sfr_addr == `RTCIA_SFR_ADR && lock_ff == 2'd2 |=>
        sfr_rdata[7] == $past(busy) && !sfr_rdata[5])
        else $error("address read wrong");
    AST_AUTO_READ_ENABLE: assert property (
        sfr_rd && sfr_addr == `RTCIA_SFR_DAT && lock_ff == 2'd2 && !busy
        |=> busy == $past(ar_ff)) else $error("autoread start wrong");
    AST_ALARM_PULSE: assert property (alarm_event |=>
        !alarm_event) else $error("alarm pulse too long");
    AST_MISS_PULSE: assert property (missing_clock_event |=>
        !missing_clock_event) else $error("missing clock pulse too long");
    cover property ($rose(busy) && !short_ff);
    cover property (sfr_rd && sfr_addr == `RTCIA_SFR_DAT && ar_ff && !busy);
    cover property (lock_ff == 2'd3);
    cover property (alarm_event);
endmodule

bind rtcia_top rtcia_checker #(.MISS_CYCLES(MISS_CYCLES)) u_chk (
    .clock(clock), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .tick_pin(tick_pin),
    .sfr_rdata(sfr_rdata), .busy(busy), .alarm_event(alarm_event),
    .missing_clock_event(missing_clock_event));

/* rtcia_defines.vh */
// constants for the locked indirect access real-time counter
// Overview of operation
// - no time limit between the two key writes, only order counts
// - wrong order, wrong key or locked access disables until reset
// - unlocked interface accepts any number of indirect accesses
// - any key register write while unlocked locks the interface again
// - key register read gives lock status and never disturbs sequence
// - status codes: locked, first key seen, unlocked, disabled
// - internal registers reachable only through address and data
// - four-bit address field selects the indirect target register
// - internal addresses zero to three are the counter bytes
// - control, oscillator, config, pin registers, then alarm bytes
// - data register write starts an indirect write of that byte
// - writing busy bit starts indirect read into data register
// - read data stays until a data write starts or the next read completes
// - address field and data register keep contents across reset
// - indirect access takes seven cycles, six with short strobe
// - short strobe on at reset, switched by address bit four
// - autoread: each data register read launches the next read
// - autoread bit six enables; software sets busy once per series
// - counter and alarm byte accesses always autoincrement address
// - counter produces alarm and missing-clock events
`ifndef RTCIA_DEFINES_VH
`define RTCIA_DEFINES_VH

// processor side register addresses
`define RTCIA_SFR_KEY      8'hae
`define RTCIA_SFR_ADR      8'hac
`define RTCIA_SFR_DAT      8'had

// key codes and lock status codes
`define RTCIA_KEY_FIRST    8'ha5
`define RTCIA_KEY_SECOND   8'hf1
`define RTCIA_CODE_LOCKED  8'h00
`define RTCIA_CODE_KEY1    8'h01
`define RTCIA_CODE_OPEN    8'h02
`define RTCIA_CODE_DEAD    8'h03

// address register fields
`define RTCIA_ADR_BUSY     7
`define RTCIA_ADR_AUTO_READ_ENABLE   6
`define RTCIA_ADR_SHORT    4
`define RTCIA_ADR_FIELD    3:0
`define RTCIA_SHORT_RST    1'b1
`define RTCIA_AUTO_READ_ENABLE_RST   1'b0

// access lengths in system clocks
`define RTCIA_LONG_CYC     3'd7
`define RTCIA_SHORT_CYC    3'd6
`define RTCIA_LEFT_LAST    3'd1

// internal register map
`define RTCIA_IA_CNT0      4'h0
`define RTCIA_IA_CNT1      4'h1
`define RTCIA_IA_CNT2      4'h2
`define RTCIA_IA_CNT3      4'h3
`define RTCIA_IA_CTL       4'h4
`define RTCIA_IA_OSCCTL    4'h5
`define RTCIA_IA_OSCCFG    4'h6
`define RTCIA_IA_PINCFG    4'h7
`define RTCIA_IA_ALM0      4'h8
`define RTCIA_IA_ALM1      4'h9
`define RTCIA_IA_ALM2      4'ha
`define RTCIA_IA_ALM3      4'hb
`define RTCIA_IA_CNT_HI    2'b00
`define RTCIA_IA_ALM_HI    2'b10

// counter control bits
`define RTCIA_CTL_RUN      0
`define RTCIA_CTL_ALMEN    1
`define RTCIA_CTL_MISSEN   2
`define RTCIA_CTL_RST      8'h00

// missing-clock timeout, 100 us of 4 ns system clocks
`define RTCIA_MISS_CYC     16'd25000

`endif

/* rtcia_sync.v */
// two-stage synchroniser with rising edge detect for the tick pin
`timescale 1ns/10ps
module rtcia_sync (
    clock,
    rst,
    pin,
    rise
);
    input  wire clock;
    input  wire rst;
    input  wire pin;
    output reg  rise;

    reg meta_ff;
    reg sync_ff;
    reg last_ff;

    always @(posedge clock) begin
        if (rst) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            last_ff <= 1'b0;
            rise    <= 1'b0;
        end else begin
            meta_ff <= pin;
            sync_ff <= meta_ff;
            last_ff <= sync_ff;
            rise    <= sync_ff & ~last_ff;
        end
    end
endmodule

/* rtcia_top.v */
// locked indirect access interface and 32-bit counter with alarm
`timescale 1ns/10ps
`include "rtcia_defines.vh"
module rtcia_top #(
    parameter [15:0] MISS_CYCLES = `RTCIA_MISS_CYC
) (
    clock,
    rst,
    sfr_addr,
    sfr_wr,
    sfr_rd,
    sfr_wdata,
    tick_pin,
    sfr_rdata,
    busy,
    alarm_event,
    missing_clock_event
);
    input  wire       clock;
    input  wire       rst;
    input  wire [7:0] sfr_addr;
    input  wire       sfr_wr;
    input  wire       sfr_rd;
    input  wire [7:0] sfr_wdata;
    input  wire       tick_pin;
    output wire [7:0] sfr_rdata;
    output wire       busy;
    output wire       alarm_event;
    output wire       missing_clock_event;

    localparam [3:0] ST_LOCKED = 4'b0001;
    localparam [3:0] ST_KEY1   = 4'b0010;
    localparam [3:0] ST_OPEN   = 4'b0100;
    localparam [3:0] ST_DEAD   = 4'b1000;

    reg  [3:0]  state_ff;
    reg  [3:0]  nxt_state;
    reg  [7:0]  state_code;
    reg  [7:0]  rdata_ff;
    reg         busy_ff;
    reg  [2:0]  left_ff;
    reg         op_wr_ff;
    reg         auto_read_enable_ff;
    reg         short_ff;
    reg  [3:0]  addr_ff;
    reg  [7:0]  data_ff;
    reg  [31:0] cnt_ff;
    reg  [31:0] nxt_cnt;
    reg  [31:0] alarm_ff;
    reg  [31:0] nxt_alarm;
    reg  [7:0]  ctl_ff;
    reg  [7:0]  oscctl_ff;
    reg  [7:0]  osccfg_ff;
    reg  [7:0]  pincfg_ff;
    reg  [7:0]  core_rdata;
    reg  [15:0] miss_cnt_ff;
    reg         alarm_ev_ff;
    reg         miss_ev_ff;

    wire        tick_rise;
    wire        key_wr;
    wire        adr_wr;
    wire        dat_wr;
    wire        adr_rd;
    wire        dat_rd;
    wire        is_open;
    wire        bad_access;
    wire        start_rd;
    wire        start_wr;
    wire        done;
    wire        core_wr;
    wire        incr_addr;
    wire        cur_short;
    wire [31:0] cnt_inc;

    rtcia_sync u_tick_sync (
        .clock (clock),
        .rst   (rst),
        .pin   (tick_pin),
        .rise  (tick_rise)
    );

    assign key_wr  = sfr_wr && (sfr_addr == `RTCIA_SFR_KEY);
    assign adr_wr  = sfr_wr && (sfr_addr == `RTCIA_SFR_ADR);
    assign dat_wr  = sfr_wr && (sfr_addr == `RTCIA_SFR_DAT);
    assign adr_rd  = sfr_rd && (sfr_addr == `RTCIA_SFR_ADR);
    assign dat_rd  = sfr_rd && (sfr_addr == `RTCIA_SFR_DAT);
    assign is_open = (state_ff == ST_OPEN);

    // any address or data access outside the unlocked state
    assign bad_access = !is_open &&
                        (adr_wr || dat_wr || adr_rd || dat_rd);

    // lock and key sequencer, no timeout between keys
    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_LOCKED: begin
                if (bad_access) begin
                    nxt_state = ST_DEAD;
                end else if (key_wr) begin
                    if (sfr_wdata == `RTCIA_KEY_FIRST) begin
                        nxt_state = ST_KEY1;
                    end else begin
                        nxt_state = ST_DEAD;
                    end
                end
            end
            ST_KEY1: begin
                if (bad_access) begin
                    nxt_state = ST_DEAD;
                end else if (key_wr) begin
                    if (sfr_wdata == `RTCIA_KEY_SECOND) begin
                        nxt_state = ST_OPEN;
                    end else begin
                        nxt_state = ST_DEAD;
                    end
                end
            end
            ST_OPEN: begin
                if (key_wr) begin
                    nxt_state = ST_LOCKED;
                end
            end
            ST_DEAD: begin
                nxt_state = ST_DEAD;
            end
            default: begin
                nxt_state = ST_DEAD;
            end
        endcase
    end

    always @(posedge clock) begin
        if (rst) begin
            state_ff <= ST_LOCKED;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always @* begin
        case (state_ff)
            ST_KEY1: state_code = `RTCIA_CODE_KEY1;
            ST_OPEN: state_code = `RTCIA_CODE_OPEN;
            ST_DEAD: state_code = `RTCIA_CODE_DEAD;
            default: state_code = `RTCIA_CODE_LOCKED;
        endcase
    end

    // indirect access launch, refused while a previous one runs
    assign start_rd = is_open && !busy_ff &&
                      ((adr_wr && sfr_wdata[`RTCIA_ADR_BUSY]) ||
                       (dat_rd && auto_read_enable_ff));
    assign start_wr = is_open && !busy_ff && dat_wr;
    assign done     = busy_ff && (left_ff == `RTCIA_LEFT_LAST);
    assign core_wr  = done && op_wr_ff;

    // an address write's own short bit times the read it starts
    assign cur_short = adr_wr ? sfr_wdata[`RTCIA_ADR_SHORT] : short_ff;

    // counter and alarm bytes step the address, others do not
    assign incr_addr = (addr_ff[3:2] == `RTCIA_IA_CNT_HI) ||
                       (addr_ff[3:2] == `RTCIA_IA_ALM_HI);

    always @(posedge clock) begin
        if (rst) begin
            busy_ff   <= 1'b0;
            left_ff   <= 3'd0;
            op_wr_ff  <= 1'b0;
            auto_read_enable_ff <= `RTCIA_AUTO_READ_ENABLE_RST;
            short_ff  <= `RTCIA_SHORT_RST;
        end else begin
            if (start_rd || start_wr) begin
                busy_ff  <= 1'b1;
                op_wr_ff <= start_wr;
                left_ff  <= cur_short ? `RTCIA_SHORT_CYC
                                      : `RTCIA_LONG_CYC;
            end else if (busy_ff) begin
                left_ff <= left_ff - `RTCIA_LEFT_LAST;
                if (done) begin
                    busy_ff <= 1'b0;
                end
            end
            if (adr_wr && is_open && !busy_ff) begin
                auto_read_enable_ff <= sfr_wdata[`RTCIA_ADR_AUTO_READ_ENABLE];
                short_ff  <= sfr_wdata[`RTCIA_ADR_SHORT];
            end
        end
    end

    // address and data survive reset, so they have no reset branch
    always @(posedge clock) begin
        if (adr_wr && is_open && !busy_ff) begin
            addr_ff <= sfr_wdata[`RTCIA_ADR_FIELD];
        end else if (done && incr_addr) begin
            addr_ff <= addr_ff + 4'd1;
        end
        if (start_wr) begin
            data_ff <= sfr_wdata;
        end else if (done && !op_wr_ff) begin
            data_ff <= core_rdata;
        end
    end

    // processor read port, address and data hidden unless unlocked
    always @(posedge clock) begin
        if (rst) begin
            rdata_ff <= 8'h00;
        end else if (sfr_rd) begin
            if (sfr_addr == `RTCIA_SFR_KEY) begin
                rdata_ff <= state_code;
            end else if (sfr_addr == `RTCIA_SFR_ADR && is_open) begin
                rdata_ff <= {busy_ff, auto_read_enable_ff, 1'b0, short_ff, addr_ff};
            end else if (sfr_addr == `RTCIA_SFR_DAT && is_open) begin
                rdata_ff <= data_ff;
            end else begin
                rdata_ff <= 8'h00;
            end
        end
    end

    // internal register read mux
    always @* begin
        case (addr_ff)
            `RTCIA_IA_CNT0:   core_rdata = cnt_ff[7:0];
            `RTCIA_IA_CNT1:   core_rdata = cnt_ff[15:8];
            `RTCIA_IA_CNT2:   core_rdata = cnt_ff[23:16];
            `RTCIA_IA_CNT3:   core_rdata = cnt_ff[31:24];
            `RTCIA_IA_CTL:    core_rdata = ctl_ff;
            `RTCIA_IA_OSCCTL: core_rdata = oscctl_ff;
            `RTCIA_IA_OSCCFG: core_rdata = osccfg_ff;
            `RTCIA_IA_PINCFG: core_rdata = pincfg_ff;
            `RTCIA_IA_ALM0:   core_rdata = alarm_ff[7:0];
            `RTCIA_IA_ALM1:   core_rdata = alarm_ff[15:8];
            `RTCIA_IA_ALM2:   core_rdata = alarm_ff[23:16];
            `RTCIA_IA_ALM3:   core_rdata = alarm_ff[31:24];
            default:          core_rdata = 8'h00;
        endcase
    end

    assign cnt_inc = cnt_ff + 32'd1;

    // counter runs on tick edges; an indirect byte write overrides
    always @* begin
        nxt_cnt   = cnt_ff;
        nxt_alarm = alarm_ff;
        if (tick_rise && ctl_ff[`RTCIA_CTL_RUN]) begin
            nxt_cnt = cnt_inc;
        end
        if (core_wr && addr_ff[3:2] == `RTCIA_IA_CNT_HI) begin
            nxt_cnt[{addr_ff[1:0], 3'b000} +: 8] = data_ff;
        end
        if (core_wr && addr_ff[3:2] == `RTCIA_IA_ALM_HI) begin
            nxt_alarm[{addr_ff[1:0], 3'b000} +: 8] = data_ff;
        end
    end

    always @(posedge clock) begin
        if (rst) begin
            cnt_ff    <= 32'h0000_0000;
            alarm_ff  <= 32'h0000_0000;
            ctl_ff    <= `RTCIA_CTL_RST;
            oscctl_ff <= 8'h00;
            osccfg_ff <= 8'h00;
            pincfg_ff <= 8'h00;
        end else begin
            cnt_ff   <= nxt_cnt;
            alarm_ff <= nxt_alarm;
            if (core_wr) begin
                if (addr_ff == `RTCIA_IA_CTL) begin
                    ctl_ff <= data_ff;
                end else if (addr_ff == `RTCIA_IA_OSCCTL) begin
                    oscctl_ff <= data_ff;
                end else if (addr_ff == `RTCIA_IA_OSCCFG) begin
                    osccfg_ff <= data_ff;
                end else if (addr_ff == `RTCIA_IA_PINCFG) begin
                    pincfg_ff <= data_ff;
                end
            end
        end
    end

    // alarm on match after a tick; missing clock after a silent timeout
    always @(posedge clock) begin
        if (rst) begin
            alarm_ev_ff <= 1'b0;
            miss_ev_ff  <= 1'b0;
            miss_cnt_ff <= 16'h0000;
        end else begin
            alarm_ev_ff <= ctl_ff[`RTCIA_CTL_ALMEN] && tick_rise &&
                           ctl_ff[`RTCIA_CTL_RUN] &&
                           (cnt_inc == alarm_ff);
            if (tick_rise || !ctl_ff[`RTCIA_CTL_MISSEN]) begin
                miss_cnt_ff <= 16'h0000;
            end else if (miss_cnt_ff != MISS_CYCLES) begin
                miss_cnt_ff <= miss_cnt_ff + 16'h0001;
            end
            miss_ev_ff <= ctl_ff[`RTCIA_CTL_MISSEN] && !tick_rise &&
                          (miss_cnt_ff == MISS_CYCLES - 16'h0001);
        end
    end

    assign sfr_rdata           = rdata_ff;
    assign busy                = busy_ff;
    assign alarm_event         = alarm_ev_ff;
    assign missing_clock_event = miss_ev_ff;
endmodule
